// file: core/platform_error_reset_policy.sv
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module platform_error_reset_policy #(
  parameter int FATAL_TIMEOUT = err_policy_pkg::FATAL_TIMEOUT_CYCLES
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic [err_policy_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [err_policy_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire err_policy_pkg::err_pins_type  err_pins,
  input  wire err_policy_pkg::pwr_pins_type  pwr_pins,
  input  wire logic                          bmc_policy_toggle,
  input  wire logic [1:0]                    bmc_policy,
  output logic                               nmi_out,
  output logic                               smi_out,
  output logic                               sys_reset_out,
  output logic                               aer_mask_out,
  output logic                               dc_power_on_out,
  output logic                               error_log_valid,
  output logic [1:0]                         error_log_code,
  output logic                               policy_to_bmc_valid,
  output logic [1:0]                         policy_to_bmc,
  output logic                               irq_out
);
  import err_policy_pkg::*;

  typedef enum logic [1:0] {PWR_NO_AC, PWR_OFF, PWR_ON} pwr_state_type;

  localparam int RST_CNT_W = $clog2(RESET_PULSE_CYCLES + 1);
  localparam logic [RST_CNT_W-1:0] RST_LOAD = RST_CNT_W'(RESET_PULSE_CYCLES);

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  logic [11:0]  pins_s;
  err_pins_type err_s;
  pwr_pins_type pwr_s;
  logic         bmc_tog_s;
  logic [1:0]   bmc_pol_s;

  sync2 #(.WIDTH(12)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({err_pins, pwr_pins, bmc_policy_toggle, bmc_policy}),
    .q       (pins_s)
  );

  assign err_s     = pins_s[11:7];
  assign pwr_s     = pins_s[6:3];
  assign bmc_tog_s = pins_s[2];
  assign bmc_pol_s = pins_s[1:0];

  // ***************************************************************
  // Register state
  // ***************************************************************
  logic [CTRL_W-1:0]    ctrl_reg;
  logic [CTRL_W-1:0]    ctrl_next;
  logic [EVT_W-1:0]     irq_status_reg;
  logic [EVT_W-1:0]     irq_status_next;
  logic [EVT_W-1:0]     irq_en_reg;
  logic [EVT_W-1:0]     irq_en_next;
  err_pins_type         err_prev_reg;
  logic                 pwr_btn_prev_reg;
  logic                 bmc_tog_prev_reg;
  logic                 cat_exp_prev_reg;
  logic                 fat_exp_prev_reg;
  logic                 was_on_reg;
  logic                 was_on_next;
  logic [RST_CNT_W-1:0] rst_cnt_reg;
  logic [RST_CNT_W-1:0] rst_cnt_next;
  pwr_state_type        pwr_state_reg;
  pwr_state_type        pwr_state_next;

  // ***************************************************************
  // Bus slave
  // ***************************************************************
  logic              aw_have_reg;
  logic              w_have_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic              wstrb0_reg;
  wire               aw_take  = s_axi_awvalid & s_axi_awready;
  wire               w_take   = s_axi_wvalid & s_axi_wready;
  wire               wr_fire  = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  wire               b_next   = wr_fire | (s_axi_bvalid & ~s_axi_bready);
  wire               aw_next  = ~wr_fire & (aw_have_reg | aw_take);
  wire               w_next   = ~wr_fire & (w_have_reg | w_take);
  wire               ar_take  = s_axi_arvalid & s_axi_arready;
  wire               r_next   = ar_take | (s_axi_rvalid & ~s_axi_rready);

  wire wr_ctrl    = wr_fire & wstrb0_reg & (awaddr_reg == CTRL_OFFSET);
  wire wr_clear   = wr_fire & wstrb0_reg & (awaddr_reg == IRQ_CLEAR_OFFSET);
  wire wr_enable  = wr_fire & wstrb0_reg & (awaddr_reg == IRQ_ENABLE_OFFSET);
  wire wr_mapped  = (awaddr_reg == CTRL_OFFSET) | (awaddr_reg == IRQ_CLEAR_OFFSET) |
                    (awaddr_reg == IRQ_ENABLE_OFFSET) | (awaddr_reg == STATUS_OFFSET) |
                    (awaddr_reg == IRQ_STATUS_OFFSET);
  wire rd_mapped  = (s_axi_araddr == CTRL_OFFSET) | (s_axi_araddr == STATUS_OFFSET) |
                    (s_axi_araddr == IRQ_STATUS_OFFSET) | (s_axi_araddr == IRQ_CLEAR_OFFSET) |
                    (s_axi_araddr == IRQ_ENABLE_OFFSET);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb0_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= AXI_OKAY;
    end else begin
      aw_have_reg   <= aw_next;
      w_have_reg    <= w_next;
      s_axi_awready <= ~aw_next & ~b_next;
      s_axi_wready  <= ~w_next & ~b_next;
      s_axi_bvalid  <= b_next;
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg  <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bresp <= wr_mapped ? AXI_OKAY : AXI_SLVERR;
      end
    end
  end

  // ***************************************************************
  // Error policy
  // ***************************************************************
  wire       serr_en    = ctrl_reg[SERR_NMI_BIT];
  wire       perr_eff   = ctrl_reg[SERR_NMI_BIT] & ctrl_reg[PERR_NMI_BIT];
  wire       aer_en     = ctrl_reg[AER_EN_BIT];
  wire [1:0] policy     = ctrl_reg[POLICY_LSB +: 2];
  wire       serr_rise  = err_s.serr & ~err_prev_reg.serr;
  wire       perr_rise  = err_s.perr & ~err_prev_reg.perr;
  wire       aer_rise   = err_s.aer & ~err_prev_reg.aer;
  wire       cat_rise   = err_s.catastrophic_error_in & ~err_prev_reg.catastrophic_error_in;
  wire       serr_nmi   = serr_rise & serr_en;
  wire       perr_nmi   = perr_rise & perr_eff;
  wire       aer_evt    = aer_rise & aer_en;
  logic      cat_exp;
  logic      fat_exp;

  // Pulse shorter than the hold time never reaches the reset path
  hold_timer #(.LIMIT(CATASTROPHIC_ERROR_IN_HOLD_CYCLES)) u_cat_hold (
    .clk_sys (clk_sys),
    .rst     (rst),
    .level   (err_s.catastrophic_error_in),
    .expired (cat_exp)
  );

  hold_timer #(.LIMIT(FATAL_TIMEOUT)) u_fatal_mon (
    .clk_sys (clk_sys),
    .rst     (rst),
    .level   (err_s.fatal_error_in),
    .expired (fat_exp)
  );

  wire cat_reset = cat_exp & ~cat_exp_prev_reg & ctrl_reg[RST_CATASTROPHIC_ERROR_IN_BIT];
  wire fat_reset = fat_exp & ~fat_exp_prev_reg & ctrl_reg[RST_FATAL_BIT];

  assign rst_cnt_next = (cat_reset | fat_reset) ? RST_LOAD :
                        (rst_cnt_reg != '0) ? rst_cnt_reg - 1'b1 : rst_cnt_reg;

  // ***************************************************************
  // Restore policy and DC power
  // ***************************************************************
  wire bmc_update = bmc_tog_s ^ bmc_tog_prev_reg;
  wire btn_rise   = pwr_s.power_button & ~pwr_btn_prev_reg;
  wire restore_on = pwr_s.config_cleared |
                    (policy == POLICY_POWER_ON) |
                    ((policy == POLICY_LAST) & was_on_reg);

  always_comb begin
    pwr_state_next = pwr_state_reg;
    was_on_next    = was_on_reg;
    case (pwr_state_reg)
      PWR_NO_AC: begin
        if (pwr_s.ac_present) begin
          pwr_state_next = restore_on ? PWR_ON : PWR_OFF;
        end
      end
      PWR_OFF: begin
        if (!pwr_s.ac_present) begin
          pwr_state_next = PWR_NO_AC;
          was_on_next    = 1'b0;
        end else if (btn_rise) begin
          pwr_state_next = PWR_ON;
        end
      end
      PWR_ON: begin
        if (!pwr_s.ac_present) begin
          pwr_state_next = PWR_NO_AC;
          was_on_next    = pwr_s.running;
        end else if (btn_rise) begin
          pwr_state_next = PWR_OFF;
        end
      end
      default: begin
        pwr_state_next = PWR_NO_AC;
      end
    endcase
  end

  // Controller owns the setting, so its update beats a same-cycle write
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = wdata_reg[CTRL_W-1:0];
    end
    if (bmc_update) begin
      ctrl_next[POLICY_LSB +: 2] = bmc_pol_s;
    end
  end

  // ***************************************************************
  // Interrupts
  // ***************************************************************
  logic [EVT_W-1:0] evt;

  always_comb begin
    evt                 = '0;
    evt[EVT_SERR]       = serr_nmi;
    evt[EVT_PERR]       = perr_nmi;
    evt[EVT_AER]        = aer_evt;
    evt[EVT_SMI]        = cat_rise;
    evt[EVT_CAT_RESET]  = cat_reset;
    evt[EVT_FAT_RESET]  = fat_reset;
    evt[EVT_POLICY_BMC] = bmc_update;
  end

  // Set beats clear so an event in the clearing cycle survives
  assign irq_status_next = (irq_status_reg & ~(wr_clear ? wdata_reg[EVT_W-1:0] : '0)) | evt;
  assign irq_en_next     = wr_enable ? wdata_reg[EVT_W-1:0] : irq_en_reg;

  // ***************************************************************
  // Read mux
  // ***************************************************************
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic [31:0] rd_word;

  always_comb begin
    ctrl_word                  = {{(32 - CTRL_W){1'b0}}, ctrl_reg};
    ctrl_word[PERR_NMI_BIT]    = perr_eff;
    status_word                = '0;
    status_word[1:0]           = policy;
    status_word[2]             = dc_power_on_out;
    status_word[3]             = was_on_reg;
    status_word[4]             = pwr_s.ac_present;
    status_word[5]             = cat_exp;
    status_word[6]             = fat_exp;
    status_word[7]             = sys_reset_out;
    status_word[8]             = pwr_s.config_cleared;
  end

  assign rd_word = (s_axi_araddr == CTRL_OFFSET)       ? ctrl_word :
                   (s_axi_araddr == STATUS_OFFSET)     ? status_word :
                   (s_axi_araddr == IRQ_STATUS_OFFSET) ? {{(32 - EVT_W){1'b0}}, irq_status_reg} :
                   (s_axi_araddr == IRQ_ENABLE_OFFSET) ? {{(32 - EVT_W){1'b0}}, irq_en_reg} :
                   32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= AXI_OKAY;
    end else begin
      s_axi_arready <= ~r_next;
      s_axi_rvalid  <= r_next;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? AXI_OKAY : AXI_SLVERR;
      end
    end
  end

  // ***************************************************************
  // State and outputs
  // ***************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg         <= CTRL_RESET[CTRL_W-1:0];
      irq_status_reg   <= '0;
      irq_en_reg       <= IRQ_ENABLE_RESET;
      err_prev_reg     <= '0;
      pwr_btn_prev_reg <= 1'b0;
      bmc_tog_prev_reg <= 1'b0;
      cat_exp_prev_reg <= 1'b0;
      fat_exp_prev_reg <= 1'b0;
      was_on_reg       <= 1'b0;
      rst_cnt_reg      <= '0;
      pwr_state_reg    <= PWR_NO_AC;
    end else begin
      ctrl_reg         <= ctrl_next;
      irq_status_reg   <= irq_status_next;
      irq_en_reg       <= irq_en_next;
      err_prev_reg     <= err_s;
      pwr_btn_prev_reg <= pwr_s.power_button;
      bmc_tog_prev_reg <= bmc_tog_s;
      cat_exp_prev_reg <= cat_exp;
      fat_exp_prev_reg <= fat_exp;
      was_on_reg       <= was_on_next;
      rst_cnt_reg      <= rst_cnt_next;
      pwr_state_reg    <= pwr_state_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nmi_out             <= 1'b0;
      smi_out             <= 1'b0;
      sys_reset_out       <= 1'b0;
      aer_mask_out        <= 1'b0;
      dc_power_on_out     <= 1'b0;
      error_log_valid     <= 1'b0;
      error_log_code      <= 2'h0;
      policy_to_bmc_valid <= 1'b0;
      policy_to_bmc       <= POLICY_STAY_OFF;
      irq_out             <= 1'b0;
    end else begin
      nmi_out             <= serr_nmi | perr_nmi;
      error_log_valid     <= serr_nmi | perr_nmi;
      error_log_code      <= {perr_nmi, serr_nmi};
      smi_out             <= cat_rise;
      sys_reset_out       <= rst_cnt_next != '0;
      aer_mask_out        <= ~ctrl_next[AER_EN_BIT];
      dc_power_on_out     <= pwr_state_next == PWR_ON;
      policy_to_bmc_valid <= wr_ctrl & ~bmc_update;
      policy_to_bmc       <= ctrl_next[POLICY_LSB +: 2];
      irq_out             <= |(irq_status_next & irq_en_next);
    end
  end

endmodule : platform_error_reset_policy
`default_nettype wire

// file: core/err_policy_pkg.sv
// Operation
// - SERR with its NMI option enabled raises an NMI and logs an error.
// - PERR with its NMI option effective raises an NMI and logs an error.
// - PERR option only counts and reads back while the SERR option is on.
// - AER support off masks every AER error; support is on after reset.
// - Held catastrophic error resets system when enabled; short pulse only gives SMI.
// - Catastrophic error never resets the system while that reset is disabled.
// - Fatal error monitor timeout resets the system when that reset is enabled.
// - Fatal error monitor timeout never resets the system while disabled.
// - Without a configuration clear, stay-off policy keeps DC power off when AC returns.
// - Power-on policy always switches DC on when AC returns.
// - Without a configuration clear, last-state policy restores DC only if it was on and running before.
// - After a configuration clear, AC return always powers the system on.
package err_policy_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam int                 ADDR_W            = 8;
  localparam logic [ADDR_W-1:0]  CTRL_OFFSET       = 8'h00;
  localparam logic [ADDR_W-1:0]  STATUS_OFFSET     = 8'h04;
  localparam logic [ADDR_W-1:0]  IRQ_STATUS_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0]  IRQ_CLEAR_OFFSET  = 8'h0C;
  localparam logic [ADDR_W-1:0]  IRQ_ENABLE_OFFSET = 8'h10;

  localparam int CTRL_W          = 7;
  localparam int SERR_NMI_BIT    = 0;
  localparam int PERR_NMI_BIT    = 1;
  localparam int AER_EN_BIT      = 2;
  localparam int RST_CATASTROPHIC_ERROR_IN_BIT  = 3;
  localparam int RST_FATAL_BIT   = 4;
  localparam int POLICY_LSB      = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_000C;

  localparam logic [1:0] POLICY_STAY_OFF = 2'h0;
  localparam logic [1:0] POLICY_LAST     = 2'h1;
  localparam logic [1:0] POLICY_POWER_ON = 2'h2;

  // ***************************************************************
  // Interrupt events
  // ***************************************************************
  localparam int EVT_W          = 7;
  localparam int EVT_SERR       = 0;
  localparam int EVT_PERR       = 1;
  localparam int EVT_AER        = 2;
  localparam int EVT_SMI        = 3;
  localparam int EVT_CAT_RESET  = 4;
  localparam int EVT_FAT_RESET  = 5;
  localparam int EVT_POLICY_BMC = 6;
  localparam logic [EVT_W-1:0] IRQ_ENABLE_RESET = 7'h00;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS       = 50;
  localparam int CATASTROPHIC_ERROR_IN_HOLD_NS      = 16000;
  localparam int CATASTROPHIC_ERROR_IN_HOLD_CYCLES  = (CATASTROPHIC_ERROR_IN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FATAL_TIMEOUT_NS    = 1000000;
  localparam int FATAL_TIMEOUT_CYCLES = (FATAL_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_NS      = 1000;
  localparam int RESET_PULSE_CYCLES  = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ***************************************************************
  // Pin groups
  // ***************************************************************
  typedef struct packed {
    logic serr;
    logic perr;
    logic aer;
    logic catastrophic_error_in;
    logic fatal_error_in;
  } err_pins_type;

  typedef struct packed {
    logic ac_present;
    logic running;
    logic power_button;
    logic config_cleared;
  } pwr_pins_type;

endpackage : err_policy_pkg

// file: core/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : sync2
`default_nettype wire

// file: core/hold_timer.sv
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
  parameter int LIMIT = 16
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic level,
  output logic      expired
);
  localparam int CNT_W = $clog2(LIMIT + 1);
  localparam logic [CNT_W-1:0] LIMIT_C = CNT_W'(LIMIT);

  logic [CNT_W-1:0] cnt_reg;

  // Any gap in the level restarts the count
  always_ff @(posedge clk_sys) begin
    if (rst || !level) begin
      cnt_reg <= '0;
      expired <= 1'b0;
    end else if (cnt_reg != LIMIT_C) begin
      cnt_reg <= cnt_reg + 1'b1;
      expired <= (cnt_reg + 1'b1) == LIMIT_C;
    end
  end
endmodule : hold_timer
`default_nettype wire

// file: testbench/bmc_model.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_model (
  input  wire logic       clk_sys,
  input  wire logic       go,
  input  wire logic [1:0] req,
  output logic            bmc_policy_toggle,
  output logic [1:0]      bmc_policy
);
  logic go_d;
  initial begin
    bmc_policy_toggle = 1'b0;
    bmc_policy = 2'h0;
    go_d = 1'b0;
  end
  // Value lands a cycle ahead of the toggle and stays until the next request
  always @(posedge clk_sys) begin
    go_d <= go;
    if (go) bmc_policy <= req;
    if (go_d) bmc_policy_toggle <= ~bmc_policy_toggle;
  end
endmodule : bmc_model
`default_nettype wire

// file: testbench/platform_error_reset_policy_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module platform_error_reset_policy_monitor (
  input wire logic                         clk_sys,
  input wire logic                         rst,
  input wire logic [1:0]                   s_axi_bresp,
  input wire logic                         s_axi_bvalid,
  input wire logic                         s_axi_bready,
  input wire logic [31:0]                  s_axi_rdata,
  input wire logic                         s_axi_rvalid,
  input wire logic                         s_axi_rready,
  input wire err_policy_pkg::err_pins_type err_pins,
  input wire err_policy_pkg::pwr_pins_type pwr_pins,
  input wire logic                         nmi_out,
  input wire logic                         smi_out,
  input wire logic                         sys_reset_out,
  input wire logic                         dc_power_on_out,
  input wire logic                         error_log_valid,
  input wire logic [1:0]                   error_log_code
);
  import err_policy_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_nmi_logged: assert property (nmi_out |-> error_log_valid && error_log_code != 2'h0)
    else $error("nmi without log entry");
  a_log_cause: assert property (error_log_valid |-> $past(err_pins.serr, 3) || $past(err_pins.perr, 3))
    else $error("log entry without error pin");
  a_smi_on_pulse: assert property ($rose(err_pins.catastrophic_error_in) |-> ##[2:6] smi_out)
    else $error("no smi after catastrophic edge");
  a_reset_cause: assert property ($rose(sys_reset_out) |->
    $past(err_pins.catastrophic_error_in, 4) || $past(err_pins.fatal_error_in, 4))
    else $error("system reset without held error");
  a_reset_width: assert property ($rose(sys_reset_out) |-> sys_reset_out [*8])
    else $error("system reset pulse too short");
  a_dc_off_noac: assert property (!pwr_pins.ac_present [*6] |-> !dc_power_on_out)
    else $error("dc on without ac");
  a_dc_needs_ac: assert property ($rose(dc_power_on_out) |-> $past(pwr_pins.ac_present, 2))
    else $error("dc rose without ac");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : platform_error_reset_policy_monitor
bind platform_error_reset_policy platform_error_reset_policy_monitor u_mon (
  .clk_sys, .rst, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .err_pins, .pwr_pins, .nmi_out, .smi_out, .sys_reset_out,
  .dc_power_on_out, .error_log_valid, .error_log_code);
`default_nettype wire

// file: testbench/platform_error_reset_policy_tb.sv
`timescale 1ns/1ps
`default_nettype none
module platform_error_reset_policy_tb;
  import err_policy_pkg::*;
  typedef struct {logic [1:0] pol; logic on; logic run; logic cfg; logic dc;} row_type;
  localparam int FT = 40;
  logic clk_sys = 1'b0, rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000, rdata, rv;
  logic awready, wready, bvalid, arready, rvalid, bmc_tgl, bmc_go = 1'b0;
  logic [1:0] bresp, rresp, rs, sc, bmc_pol, log_code, to_bmc, bmc_req = 2'h0;
  logic nmi, smi, sysrst, aer_mask, dc, log_v, to_bmc_v, irq, sn, ss, sr;
  err_pins_type ep = '0;
  pwr_pins_type pp = 4'b1000;
  int miscompares = 0, checks_done = 0, cycles = 0;
  row_type rows [6] = '{'{2'h0, 1, 1, 0, 0}, '{2'h2, 0, 0, 0, 1}, '{2'h1, 1, 1, 0, 1},
                        '{2'h1, 1, 0, 0, 0}, '{2'h1, 0, 0, 0, 0}, '{2'h0, 0, 0, 1, 1}};
  platform_error_reset_policy #(.FATAL_TIMEOUT(FT)) DUT (
    .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .err_pins(ep), .pwr_pins(pp),
    .bmc_policy_toggle(bmc_tgl), .bmc_policy(bmc_pol), .nmi_out(nmi), .smi_out(smi),
    .sys_reset_out(sysrst), .aer_mask_out(aer_mask), .dc_power_on_out(dc), .error_log_valid(log_v),
    .error_log_code(log_code), .policy_to_bmc_valid(to_bmc_v), .policy_to_bmc(to_bmc), .irq_out(irq));
  bmc_model u_bmc (.clk_sys(clk_sys), .go(bmc_go), .req(bmc_req), .bmc_policy_toggle(bmc_tgl),
    .bmc_policy(bmc_pol));
  always #25 clk_sys = ~clk_sys;
  // Whole run needs some 1540 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Ready stands high while the slave is idle, so valid is taken on its first edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_sys);
      if (awvalid && awready) ad = 1'b1;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wd = 1'b1;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    @(posedge clk_sys);
    bready <= 1'b1;
    do @(posedge clk_sys); while (!bvalid);
    bready <= 1'b0;
    rs = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    @(posedge clk_sys);
    rready <= 1'b1;
    do @(posedge clk_sys); while (!rvalid);
    rready <= 1'b0;
    rv = rdata;
    rs = rresp;
  endtask : rd
  task automatic watch(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (nmi) sc = log_code;
      sn = sn | nmi;
      ss = ss | smi;
      sr = sr | sysrst;
    end
  endtask : watch
  task automatic pin(input int b, input int n);
    sn = 1'b0;
    ss = 1'b0;
    sr = 1'b0;
    ep[b] <= 1'b1;
    watch(n);
    ep[b] <= 1'b0;
    watch(40);
  endtask : pin
  task automatic press();
    pp.power_button <= 1'b1;
    repeat (4) @(posedge clk_sys);
    pp.power_button <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask : press
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      wr(CTRL_OFFSET, {25'h0, rows[i].pol, 5'h0C});
      check(to_bmc, rows[i].pol);
      rd(STATUS_OFFSET);
      if (rv[2] !== rows[i].on) press();
      pp.running <= rows[i].run;
      repeat (4) @(posedge clk_sys);
      pp.ac_present <= 1'b0;
      repeat (10) @(posedge clk_sys);
      rd(STATUS_OFFSET);
      check(rv[3], rows[i].on & rows[i].run);
      pp.config_cleared <= rows[i].cfg;
      pp.ac_present <= 1'b1;
      repeat (12) @(posedge clk_sys);
      check(dc, rows[i].dc);
      pp.config_cleared <= 1'b0;
    end
    // ***************************************************************
    // Hand-written cases
    // ***************************************************************
    rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(CTRL_OFFSET);
    check(rv, CTRL_RESET);
    check(aer_mask, 1'b0);
    rd(IRQ_ENABLE_OFFSET);
    check(rv, 32'h0000_0000);
    rd(8'h14);
    check(rs, AXI_SLVERR);
    wr(CTRL_OFFSET, 32'h0000_000E);
    rd(CTRL_OFFSET);
    check(rv[1], 1'b0);
    pin(4, 3);
    check(sn, 1'b0);
    pin(3, 3);
    check(sn, 1'b0);
    wr(CTRL_OFFSET, 32'h0000_000F);
    pin(3, 3);
    check({sn, sc}, 3'b110);
    wr(IRQ_CLEAR_OFFSET, 32'h0000_007F);
    pin(4, 3);
    check({sn, sc}, 3'b101);
    check(irq, 1'b0);
    wr(IRQ_ENABLE_OFFSET, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    check(irq, 1'b1);
    wr(IRQ_CLEAR_OFFSET, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    check(irq, 1'b0);
    wr(CTRL_OFFSET, 32'h0000_000B);
    repeat (3) @(posedge clk_sys);
    check(aer_mask, 1'b1);
    wr(CTRL_OFFSET, 32'h0000_000C);
    pin(1, 3);
    check({ss, sr}, 2'b10);
    pin(1, 340);
    check(sr, 1'b1);
    wr(CTRL_OFFSET, 32'h0000_0004);
    pin(1, 400);
    check(sr, 1'b0);
    pin(0, FT + 20);
    check(sr, 1'b0);
    wr(CTRL_OFFSET, 32'h0000_0014);
    pin(0, FT + 10);
    check(sr, 1'b1);
    bmc_req <= POLICY_POWER_ON;
    bmc_go <= 1'b1;
    @(posedge clk_sys);
    bmc_go <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rd(STATUS_OFFSET);
    check(rv[1:0], POLICY_POWER_ON);
    report_and_stop();
  end
endmodule : platform_error_reset_policy_tb
`default_nettype wire
